//--- common/cbo_pkg.sv
package cbo_pkg;
  // Oscillator periods per prescaler step
  localparam int unsigned QUANTUM_MULT = 2;
  localparam int unsigned ID_BITS = 11;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_CTRL = 6'h20;
  localparam logic [5:0] IDX_STATUS = 6'h21;
  localparam logic [5:0] IDX_PRESCALE = 6'h26;
  localparam logic [5:0] IDX_SEGMENTS = 6'h27;
  localparam logic [5:0] IDX_OUTCTL = 6'h28;
  localparam logic [5:0] IDX_ID_HIGH = 6'h2a;
  localparam logic [5:0] IDX_LEN_TYPE = 6'h2b;
  // Reset values
  localparam logic [7:0] RST_PRESCALE = 8'h00;
  localparam logic [7:0] RST_SEGMENTS = 8'h00;
  localparam logic [7:0] RST_OUTCTL = 8'h00;
  localparam logic [7:0] RST_ID_HIGH = 8'h00;
  localparam logic [7:0] RST_LEN_TYPE = 8'h00;
  localparam logic RST_RESET_REQ = 1'b1;
  // Control and status bit positions
  localparam int unsigned CTRL_RESET_REQ = 0;
  localparam int unsigned CTRL_ID_START = 1;
  localparam int unsigned STAT_ID_BUSY = 0;
  localparam int unsigned STAT_ARB_LOST = 1;
  localparam int unsigned STAT_ID_DONE = 2;
  localparam int unsigned STAT_SAMPLE = 3;
  // Field positions
  localparam int unsigned JW_LSB = 6;
  localparam int unsigned SEG2_LSB = 4;
  localparam int unsigned TRIPLE_POS = 7;
  localparam int unsigned MODE_LSB = 0;
  localparam int unsigned POL0_POS = 2;
  localparam int unsigned LOW0_POS = 3;
  localparam int unsigned HIGH0_POS = 4;
  localparam int unsigned POL1_POS = 5;
  localparam int unsigned LOW1_POS = 6;
  localparam int unsigned HIGH1_POS = 7;
  localparam int unsigned ID_LOW_LSB = 5;
  // Output coding modes
  typedef enum logic [1:0] {
    MODE_BIPHASE = 2'b00,
    MODE_UNUSED = 2'b01,
    MODE_NORMAL1 = 2'b10,
    MODE_NORMAL2 = 2'b11
  } cbo_mode_t;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : cbo_pkg

//--- verilog/cbo_bit_timing.sv
// Operation
// - Timing and output config registers accessible only while reset request is set.
// - Jump width equals field plus one quanta, one to four.
// - Prescaler value equals field plus one, 1 to 64, sets quantum length.
// - Triple-sample bit set takes three samples per bit, else one.
// - In triple mode the sample point is the last of three samples.
// - First segment is field plus one quanta; second segment field plus one.
// - Bit is one sync quantum, then first segment, then second segment.
// - Edges outside sync segment adjust the bit by at most jump width.
// - Transmit value changes only at bit start; receive samples at sample point. Code also forces recessive at once on reset request.
// - Output mode selects biphase, unused, both lines data, or data plus clock.
// - Clock-output line is high for the one-quantum sync segment.
// - Internal transmit bit is zero for dominant, one for recessive.
// - Biphase toggles per dominant bit, first on line a, recessive floats.
// - Normal mode one drives the bit stream unchanged on both lines.
// - Data xor polarity picks low or high driver, gated by its enable.
// - Identifier is eleven bits, MSB first; upper eight in identifier register.
// - Low three identifier bits sit in bits 7 to 5 of next register.
// - Smaller identifier wins; losing node stops on recessive overwritten by dominant.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/10ps
module cbo_bit_timing (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic rx_bit_i,
  output logic high_side_state_a_o,
  output logic low_side_state_a_o,
  output logic high_side_state_b_o,
  output logic low_side_state_b_o,
  output logic internal_tx_bit_o,
  output logic bit_start_o,
  output logic sample_strobe_o,
  output logic sampled_bit_o
);

  typedef struct packed {
    logic awready;
    logic aw_hold;
    logic [5:0] aw_idx;
    logic wready;
    logic w_hold;
    logic w_en;
    logic [7:0] w_byte;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic reset_req;
    logic [7:0] prescale;
    logic [7:0] segments;
    logic [7:0] outctl;
    logic [7:0] id_high;
    logic [7:0] len_type;
    logic arb_lost;
    logic id_done;
    logic id_active;
    logic id_tx;
    logic [10:0] id_sh;
    logic [3:0] id_cnt;
    logic [7:0] pre_cnt;
    logic [4:0] q;
    logic [4:0] sample_pos;
    logic [4:0] end_pos;
    logic resync_done;
    logic rx_prev;
    logic s1;
    logic s2;
    logic sampled;
    logic smp_stb;
    logic bit_start;
    logic td;
    logic tog;
    logic ha;
    logic la;
    logic hb;
    logic lb;
  } cbo_state_t;

  cbo_state_t r;
  cbo_state_t next_r;

  // Registers guarded by the reset request
  function automatic logic cfg_idx(input logic [5:0] i);
    cfg_idx = (i == cbo_pkg::IDX_PRESCALE) || (i == cbo_pkg::IDX_SEGMENTS) || (i == cbo_pkg::IDX_OUTCTL);
  endfunction : cfg_idx

  function automatic logic mapped(input logic [5:0] i);
    mapped = cfg_idx(i) || (i == cbo_pkg::IDX_CTRL) || (i == cbo_pkg::IDX_STATUS)
      || (i == cbo_pkg::IDX_ID_HIGH) || (i == cbo_pkg::IDX_LEN_TYPE);
  endfunction : mapped

  // Per-line driver decode: data xor polarity picks the transistor
  function automatic logic [1:0] drive(input logic en, input logic d, input logic pol,
                                       input logic hi_en, input logic lo_en);
    logic x;
    x = d ^ pol;
    drive = {en & x & hi_en, en & ~x & lo_en};
  endfunction : drive

  // Read mux; config reads as zero outside reset request
  function automatic logic [7:0] rd_val(input cbo_state_t s, input logic [5:0] i);
    rd_val = 8'h00;
    if (cfg_idx(i) && !s.reset_req)
      rd_val = 8'h00;
    else if (i == cbo_pkg::IDX_CTRL)
      rd_val = {7'h00, s.reset_req};
    else if (i == cbo_pkg::IDX_STATUS)
      rd_val = {4'h0, s.sampled, s.id_done, s.arb_lost, s.id_active};
    else if (i == cbo_pkg::IDX_PRESCALE)
      rd_val = s.prescale;
    else if (i == cbo_pkg::IDX_SEGMENTS)
      rd_val = s.segments;
    else if (i == cbo_pkg::IDX_OUTCTL)
      rd_val = s.outctl;
    else if (i == cbo_pkg::IDX_ID_HIGH)
      rd_val = s.id_high;
    else if (i == cbo_pkg::IDX_LEN_TYPE)
      rd_val = s.len_type;
  endfunction : rd_val

  logic [4:0] ts1;
  logic [4:0] ts2;
  logic [4:0] resync_jump_width;
  logic [7:0] pre_top;
  logic triple;
  cbo_pkg::cbo_mode_t mode;

  // Decoded timing fields
  always_comb
  begin
    ts1 = 5'(r.segments[3:0]) + 5'h01;
    ts2 = 5'(r.segments[cbo_pkg::SEG2_LSB +: 3]) + 5'h01;
    resync_jump_width = 5'(r.prescale[cbo_pkg::JW_LSB +: 2]) + 5'h01;
    pre_top = 8'((9'(r.prescale[5:0]) + 9'h001) * 9'(cbo_pkg::QUANTUM_MULT) - 9'h001);
    triple = r.segments[cbo_pkg::TRIPLE_POS];
    mode = cbo_pkg::cbo_mode_t'(r.outctl[cbo_pkg::MODE_LSB +: 2]);
  end

  // Next-state logic: bus slave first, engine after so hardware sets win
  always_comb
  begin
    logic tick;
    logic edge_seen;
    logic restart;
    logic sval;
    logic [4:0] l;
    logic [4:0] err;
    logic en_a;
    logic en_b;
    logic d_a;
    logic d_b;
    logic [1:0] pa;
    logic [1:0] pb;
    tick = 1'b0;
    edge_seen = 1'b0;
    restart = 1'b0;
    sval = 1'b1;
    l = 5'h00;
    err = 5'h00;
    en_a = 1'b0;
    en_b = 1'b0;
    d_a = 1'b1;
    d_b = 1'b1;
    pa = 2'b00;
    pb = 2'b00;
    next_r = r;
    next_r.smp_stb = 1'b0;
    next_r.bit_start = 1'b0;

    // Write address and data taken in either order
    if (s_axi_awvalid_i && r.awready)
    begin
      next_r.aw_hold = 1'b1;
      next_r.aw_idx = s_axi_awaddr_i[7:2];
    end
    if (s_axi_wvalid_i && r.wready)
    begin
      next_r.w_hold = 1'b1;
      next_r.w_byte = s_axi_wdata_i[7:0];
      next_r.w_en = s_axi_wstrb_i[0];
    end
    if (r.bvalid && s_axi_bready_i)
      next_r.bvalid = 1'b0;

    // Commit once both halves are held and no response is pending
    if (r.aw_hold && r.w_hold && !r.bvalid)
    begin
      next_r.aw_hold = 1'b0;
      next_r.w_hold = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = mapped(r.aw_idx) ? cbo_pkg::RESP_OKAY : cbo_pkg::RESP_SLVERR;
      if (r.w_en)
      begin
        if (cfg_idx(r.aw_idx) && !r.reset_req)
          next_r.bresp = cbo_pkg::RESP_OKAY;
        else if (r.aw_idx == cbo_pkg::IDX_PRESCALE)
          next_r.prescale = r.w_byte;
        else if (r.aw_idx == cbo_pkg::IDX_SEGMENTS)
          next_r.segments = r.w_byte;
        else if (r.aw_idx == cbo_pkg::IDX_OUTCTL)
          next_r.outctl = r.w_byte;
        else if (r.aw_idx == cbo_pkg::IDX_ID_HIGH)
          next_r.id_high = r.w_byte;
        else if (r.aw_idx == cbo_pkg::IDX_LEN_TYPE)
          next_r.len_type = r.w_byte;
        else if (r.aw_idx == cbo_pkg::IDX_STATUS)
        begin
          // Write one to clear; a same-cycle set below still wins
          if (r.w_byte[cbo_pkg::STAT_ARB_LOST])
            next_r.arb_lost = 1'b0;
          if (r.w_byte[cbo_pkg::STAT_ID_DONE])
            next_r.id_done = 1'b0;
        end
        else if (r.aw_idx == cbo_pkg::IDX_CTRL)
        begin
          next_r.reset_req = r.w_byte[cbo_pkg::CTRL_RESET_REQ];
          // Start ignored while the engine is held
          if (r.w_byte[cbo_pkg::CTRL_ID_START] && !r.w_byte[cbo_pkg::CTRL_RESET_REQ] && !r.id_active)
          begin
            next_r.id_active = 1'b1;
            next_r.id_tx = 1'b0;
            next_r.id_cnt = 4'h0;
            next_r.id_sh = {r.id_high, r.len_type[cbo_pkg::ID_LOW_LSB +: 3]};
          end
        end
      end
    end
    next_r.awready = !next_r.aw_hold;
    next_r.wready = !next_r.w_hold;

    // Read channel: one beat, arready drops until rdata taken
    if (r.rvalid && s_axi_rready_i)
    begin
      next_r.rvalid = 1'b0;
      next_r.arready = 1'b1;
    end
    else if (s_axi_arvalid_i && r.arready)
    begin
      next_r.arready = 1'b0;
      next_r.rvalid = 1'b1;
      next_r.rdata = rd_val(r, s_axi_araddr_i[7:2]);
      next_r.rresp = mapped(s_axi_araddr_i[7:2]) ? cbo_pkg::RESP_OKAY : cbo_pkg::RESP_SLVERR;
    end

    // Engine held idle and recessive during reset request
    if (r.reset_req)
    begin
      next_r.pre_cnt = 8'h00;
      next_r.q = 5'h00;
      next_r.td = 1'b1;
      next_r.tog = 1'b0;
      next_r.id_active = 1'b0;
      next_r.id_tx = 1'b0;
      next_r.resync_done = 1'b0;
      next_r.rx_prev = 1'b1;
      next_r.sample_pos = ts1;
      next_r.end_pos = ts1 + ts2;
    end
    else
    begin
      // Quantum tick from the prescaler
      if (r.pre_cnt == pre_top)
      begin
        next_r.pre_cnt = 8'h00;
        tick = 1'b1;
      end
      else
        next_r.pre_cnt = r.pre_cnt + 8'h01;

      if (tick)
      begin
        next_r.rx_prev = rx_bit_i;
        edge_seen = r.rx_prev && !rx_bit_i;
        // No resync on own dominant bit; one adjustment per bit
        if (edge_seen && !r.resync_done && r.td && r.q != 5'h00)
        begin
          next_r.resync_done = 1'b1;
          if (r.q <= r.sample_pos)
          begin
            // Late edge: lengthen first segment
            l = (r.q < resync_jump_width) ? r.q : resync_jump_width;
            next_r.sample_pos = r.sample_pos + l;
            next_r.end_pos = r.end_pos + l;
          end
          else
          begin
            // Early edge: shorten second segment
            err = r.end_pos + 5'h01 - r.q;
            if (err <= resync_jump_width)
              restart = 1'b1;
            else
              next_r.end_pos = r.end_pos - resync_jump_width;
          end
        end

        // Two early samples precede the sample point
        if (r.q == r.sample_pos - 5'h02)
          next_r.s1 = rx_bit_i;
        if (r.q == r.sample_pos - 5'h01)
          next_r.s2 = rx_bit_i;
        if (r.q == r.sample_pos && !restart)
        begin
          // Majority vote of three, last one at the sample point
          if (triple)
            sval = (r.s1 & r.s2) | (r.s1 & rx_bit_i) | (r.s2 & rx_bit_i);
          else
            sval = rx_bit_i;
          next_r.sampled = sval;
          next_r.smp_stb = 1'b1;
          if (r.id_active && r.id_tx)
          begin
            // Recessive sent but dominant seen: a lower identifier won
            if (r.td && !sval)
            begin
              next_r.arb_lost = 1'b1;
              next_r.id_active = 1'b0;
            end
            else if (r.id_cnt == 4'(cbo_pkg::ID_BITS - 1))
            begin
              next_r.id_done = 1'b1;
              next_r.id_active = 1'b0;
            end
            else
              next_r.id_cnt = r.id_cnt + 4'h1;
          end
        end

        // Bit boundary: sync quantum, then first and second segments
        if (r.q == r.end_pos || restart)
        begin
          next_r.q = 5'h00;
          next_r.bit_start = 1'b1;
          next_r.resync_done = 1'b0;
          next_r.sample_pos = ts1;
          next_r.end_pos = ts1 + ts2;
          // Outside reset request, a new value goes out only here, the transmit point
          if (next_r.id_active)
          begin
            next_r.td = next_r.id_sh[10];
            next_r.id_sh = {next_r.id_sh[9:0], 1'b0};
            next_r.id_tx = 1'b1;
          end
          else
          begin
            next_r.td = 1'b1;
            next_r.id_tx = 1'b0;
          end
          if (mode == cbo_pkg::MODE_BIPHASE && !next_r.td)
            next_r.tog = !r.tog;
        end
        else
          next_r.q = r.q + 5'h01;
      end
    end

    // Output coding per mode; dominant is a zero internally
    unique case (mode)
      cbo_pkg::MODE_BIPHASE:
      begin
        d_a = 1'b0;
        d_b = 1'b0;
        en_a = !next_r.td && next_r.tog;
        en_b = !next_r.td && !next_r.tog;
      end
      cbo_pkg::MODE_UNUSED:
      begin
        en_a = 1'b0;
        en_b = 1'b0;
      end
      cbo_pkg::MODE_NORMAL1:
      begin
        d_a = next_r.td;
        d_b = next_r.td;
        en_a = 1'b1;
        en_b = 1'b1;
      end
      cbo_pkg::MODE_NORMAL2:
      begin
        d_a = next_r.td;
        d_b = (next_r.q == 5'h00);
        en_a = 1'b1;
        en_b = 1'b1;
      end
    endcase
    pa = drive(en_a, d_a, r.outctl[cbo_pkg::POL0_POS], r.outctl[cbo_pkg::HIGH0_POS], r.outctl[cbo_pkg::LOW0_POS]);
    pb = drive(en_b, d_b, r.outctl[cbo_pkg::POL1_POS], r.outctl[cbo_pkg::HIGH1_POS], r.outctl[cbo_pkg::LOW1_POS]);
    next_r.ha = pa[1];
    next_r.la = pa[0];
    next_r.hb = pb[1];
    next_r.lb = pb[0];
  end

  // State register
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      r <= '0;
      r.awready <= 1'b1;
      r.wready <= 1'b1;
      r.arready <= 1'b1;
      r.reset_req <= cbo_pkg::RST_RESET_REQ;
      r.prescale <= cbo_pkg::RST_PRESCALE;
      r.segments <= cbo_pkg::RST_SEGMENTS;
      r.outctl <= cbo_pkg::RST_OUTCTL;
      r.id_high <= cbo_pkg::RST_ID_HIGH;
      r.len_type <= cbo_pkg::RST_LEN_TYPE;
      r.td <= 1'b1;
      r.rx_prev <= 1'b1;
      r.sampled <= 1'b1;
    end
    else
      r <= next_r;
  end

  // Every output straight from the state register
  assign s_axi_awready_o = r.awready;
  assign s_axi_wready_o = r.wready;
  assign s_axi_bresp_o = r.bresp;
  assign s_axi_bvalid_o = r.bvalid;
  assign s_axi_arready_o = r.arready;
  assign s_axi_rdata_o = {24'h00_0000, r.rdata};
  assign s_axi_rresp_o = r.rresp;
  assign s_axi_rvalid_o = r.rvalid;
  assign high_side_state_a_o = r.ha;
  assign low_side_state_a_o = r.la;
  assign high_side_state_b_o = r.hb;
  assign low_side_state_b_o = r.lb;
  assign internal_tx_bit_o = r.td;
  assign bit_start_o = r.bit_start;
  assign sample_strobe_o = r.smp_stb;
  assign sampled_bit_o = r.sampled;

endmodule : cbo_bit_timing

//--- dv/cbo_can_node_model.sv
`timescale 1ns/10ps
// Other nodes and transceiver on a wired-AND bus
module cbo_can_node_model (
  input wire logic tx_bit_i,
  input wire logic other_dominant_i,
  output logic rx_bit_o
);
  // Dominant (0) from any node wins over recessive, so a lower identifier wins
  assign rx_bit_o = tx_bit_i & ~other_dominant_i;
endmodule : cbo_can_node_model

//--- dv/cbo_bit_timing_asserts.sv
`timescale 1ns/10ps
module cbo_bit_timing_asserts (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic high_side_state_a_o,
  input wire logic low_side_state_a_o,
  input wire logic high_side_state_b_o,
  input wire logic low_side_state_b_o,
  input wire logic internal_tx_bit_o,
  input wire logic bit_start_o,
  input wire logic sample_strobe_o
);
  // One clock domain, so defaults save repeating clock and reset
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  // Bus handshakes and hold behaviour
  AST_B_STANDS: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped before bready");
  AST_R_STANDS: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)
    && $stable(s_axi_rresp_o)) else $error("read response changed before rready");
  AST_R_UPPER_ZERO: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  AST_B_LATENCY: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
    && !s_axi_bvalid_o |-> ##2 s_axi_bvalid_o) else $error("write response late");
  AST_AW_HELD: assert property (s_axi_awvalid_i && s_axi_awready_o |=> !s_axi_awready_o)
    else $error("awready high while address held");
  AST_R_LATENCY: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o)
    else $error("read response late");
  // Line behaviour
  AST_TX_AT_BIT_START: assert property ($changed(internal_tx_bit_o) |-> bit_start_o)
    else $error("transmit bit changed away from bit start");
  AST_NO_SHOOT: assert property (!(high_side_state_a_o && low_side_state_a_o)
    && !(high_side_state_b_o && low_side_state_b_o)) else $error("both drivers of a line on");
  AST_BIT_PULSE: assert property (bit_start_o |=> !bit_start_o && !sample_strobe_o)
    else $error("bit start not followed by sync quantum");
  AST_SAMPLE_PULSE: assert property (sample_strobe_o |=> !sample_strobe_o)
    else $error("sample strobe longer than one cycle");

  // Main scenarios
  COV_SLVERR: cover property (s_axi_bvalid_o && s_axi_bready_i && s_axi_bresp_o == 2'b10);
  COV_DOMINANT: cover property (bit_start_o && !internal_tx_bit_o);
  COV_SAMPLE: cover property (sample_strobe_o ##1 !sample_strobe_o);
endmodule : cbo_bit_timing_asserts

bind cbo_bit_timing cbo_bit_timing_asserts u_cbo_bit_timing_asserts (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
  .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i), .high_side_state_a_o(high_side_state_a_o),
  .low_side_state_a_o(low_side_state_a_o), .high_side_state_b_o(high_side_state_b_o),
  .low_side_state_b_o(low_side_state_b_o), .internal_tx_bit_o(internal_tx_bit_o), .bit_start_o(bit_start_o),
  .sample_strobe_o(sample_strobe_o));

//--- dv/cbo_bit_timing_test.sv
`timescale 1ns/10ps
module cbo_bit_timing_test;
  localparam logic [5:0] CFG_IDX [5] = '{cbo_pkg::IDX_PRESCALE, cbo_pkg::IDX_SEGMENTS, cbo_pkg::IDX_OUTCTL,
    cbo_pkg::IDX_ID_HIGH, cbo_pkg::IDX_LEN_TYPE};
  localparam logic [7:0] CFG_RST [5] = '{cbo_pkg::RST_PRESCALE, cbo_pkg::RST_SEGMENTS, cbo_pkg::RST_OUTCTL,
    cbo_pkg::RST_ID_HIGH, cbo_pkg::RST_LEN_TYPE};
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, other_dom = 1'b0;
  logic rx_bit;
  wire logic awready, wready, bvalid, arready, rvalid, ha, la, hb, lb, tx_bit, bit_start, sample_strobe, sampled;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  logic [31:0] rd_data;
  logic [1:0] last_resp;
  logic [7:0] last_bt0;
  int unsigned cyc = 0;
  int miscompares = 0;
  int check_count = 0;

  cbo_bit_timing u_cbo_bit_timing (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'h1),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .rx_bit_i(rx_bit), .high_side_state_a_o(ha), .low_side_state_a_o(la), .high_side_state_b_o(hb),
    .low_side_state_b_o(lb), .internal_tx_bit_o(tx_bit), .bit_start_o(bit_start),
    .sample_strobe_o(sample_strobe), .sampled_bit_o(sampled));
  cbo_can_node_model u_cbo_can_node_model (.tx_bit_i(tx_bit), .other_dominant_i(other_dom), .rx_bit_o(rx_bit));

  // Free-running clock and a cycle count for timing checks
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) cyc <= cyc + 1;

  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [5:0] idx, input logic [31:0] data);
    logic aw_done;
    logic w_done;
    @(posedge sys_clk);
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= {idx, 2'b00};
    wdata <= data;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      aw_done = aw_done || (awready === 1'b1);
      w_done = w_done || (wready === 1'b1);
      if (aw_done) awvalid <= 1'b0;
      if (w_done) wvalid <= 1'b0;
    end while (!(aw_done && w_done));
    while (bvalid !== 1'b1) @(posedge sys_clk);
    bready <= 1'b1;
    @(posedge sys_clk);
    last_resp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] idx);
    @(posedge sys_clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (rvalid !== 1'b1);
    rready <= 1'b1;
    @(posedge sys_clk);
    rd_data = rdata;
    last_resp = rresp;
    rready <= 1'b0;
  endtask : rd

  // Returns 1 ns after the edge that shows the pulse, so values are settled
  task automatic wait_evt(input logic want_sample);
    do
    begin
      @(posedge sys_clk);
      #1;
    end while ((want_sample ? sample_strobe : bit_start) !== 1'b1);
  endtask : wait_evt

  // Driver pair {high, low} of one line
  function automatic logic [1:0] drv(input logic x, input logic pol, input logic hi_en, input logic lo_en);
    return {hi_en & (x ^ pol), lo_en & ~(x ^ pol)};
  endfunction : drv

  function automatic logic [3:0] exp_pins(input logic [1:0] m, input logic d, input logic q, input logic ck,
    input logic [7:0] oc);
    logic [1:0] a;
    logic [1:0] b;
    a = drv(d, oc[2], oc[4], oc[3]);
    b = drv(m[0] ? ck : d, oc[5], oc[7], oc[6]);
    if (m == 2'b01) return 4'h0;
    if (m == 2'b00) return {(!d && q) ? drv(1'b0, oc[2], oc[4], oc[3]) : 2'b00,
      (!d && !q) ? drv(1'b0, oc[5], oc[7], oc[6]) : 2'b00};
    return {a, b};
  endfunction : exp_pins

  // One identifier frame; with lose set another node wins at the second bit
  task automatic run_frame(input logic [1:0] mode, input logic lose);
    logic [7:0] oc;
    logic [7:0] bt1;
    logic [7:0] id_hi;
    logic [7:0] len;
    logic [10:0] id;
    logic q;
    logic d;
    int qn;
    int unsigned t0;
    wr(cbo_pkg::IDX_CTRL, 32'h0000_0001);
    last_bt0 = {2'($urandom_range(1)), 6'($urandom_range(3, 1))};
    bt1 = {(last_bt0[5:0] > 6'h01) && ($urandom_range(1) == 1), 3'h2, 4'($urandom_range(7, 3))};
    oc = {6'($urandom), mode};
    id_hi = lose ? 8'h40 : {1'b0, 7'($urandom)};
    len = 8'($urandom);
    id = {id_hi, len[7:5]};
    wr(cbo_pkg::IDX_PRESCALE, 32'(last_bt0));
    wr(cbo_pkg::IDX_SEGMENTS, 32'(bt1));
    wr(cbo_pkg::IDX_OUTCTL, 32'(oc));
    wr(cbo_pkg::IDX_ID_HIGH, 32'(id_hi));
    wr(cbo_pkg::IDX_LEN_TYPE, 32'(len));
    wr(cbo_pkg::IDX_CTRL, 32'h0000_0000);
    qn = (int'(last_bt0[5:0]) + 1) * cbo_pkg::QUANTUM_MULT;
    wait_evt(1'b0);
    t0 = cyc;
    // Late edge at quantum 3 stretches the bit by the jump width
    repeat (3 * qn) @(posedge sys_clk);
    other_dom <= 1'b1;
    wait_evt(1'b0);
    qn = qn * (int'(bt1[3:0]) + 6 + int'(last_bt0[7:6]));
    check_val("bit period", qn, cyc - t0);
    wr(cbo_pkg::IDX_CTRL, 32'h0000_0002);
    q = 1'b0;
    for (int i = 0; i < 11; i++)
    begin
      wait_evt(1'b0);
      @(posedge sys_clk);
      #1;
      d = (lose && i == 2) ? 1'b1 : id[10 - i];
      check_val("tx bit", 32'(d), 32'(tx_bit));
      if (mode == 2'b00 && !d) q = ~q;
      @(posedge sys_clk);
      #1;
      check_val("pins sync", 32'(exp_pins(mode, d, q, 1'b1, oc)), 32'({ha, la, hb, lb}));
      // Bit 0 is dominant, so releasing here makes no edge
      @(posedge sys_clk);
      other_dom <= lose && i == 1;
      if (lose && i == 2) break;
      wait_evt(1'b1);
      repeat (2) @(posedge sys_clk);
      #1;
      check_val("pins mid", 32'(exp_pins(mode, d, q, 1'b0, oc)), 32'({ha, la, hb, lb}));
      check_val("sampled bit", 32'(d && !(lose && i == 1)), 32'(sampled));
    end
    rd(cbo_pkg::IDX_STATUS);
    check_val("status", lose ? 32'h0000_0002 : 32'h0000_0004, rd_data & 32'h0000_0006);
    wr(cbo_pkg::IDX_STATUS, 32'h0000_0006);
  endtask : run_frame

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  // Watchdog well beyond the expected few thousand cycles
  initial
  begin
    repeat (40000) @(posedge sys_clk);
    miscompares++;
    test_done();
  end

  initial
  begin
    logic [31:0] w;
    w = $urandom(49191);
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(cbo_pkg::IDX_CTRL);
    check_val("ctrl reset", 32'(cbo_pkg::RST_RESET_REQ), rd_data & 32'h0000_0001);
    // Reset values and read-back while reset request is set
    for (int i = 0; i < 5; i++)
    begin
      rd(CFG_IDX[i]);
      check_val("reset value", 32'(CFG_RST[i]), rd_data);
      w = $urandom;
      wr(CFG_IDX[i], w);
      rd(CFG_IDX[i]);
      check_val("readback", {24'h00_0000, w[7:0]}, rd_data);
    end
    // Reserved index between output control and identifier
    rd(6'h29);
    check_val("reserved read", {30'h0000_0000, cbo_pkg::RESP_SLVERR}, {rd_data[29:0], last_resp});
    wr(6'h29, 32'h0000_00ff);
    check_val("reserved write", 32'(cbo_pkg::RESP_SLVERR), 32'(last_resp));
    for (int m = 0; m < 4; m++) run_frame(2'(m), 1'b0);
    run_frame(2'b10, 1'b1);
    // Engine running: configuration closed to software
    wr(cbo_pkg::IDX_PRESCALE, 32'h0000_003f);
    check_val("gated write resp", 32'(cbo_pkg::RESP_OKAY), 32'(last_resp));
    rd(cbo_pkg::IDX_PRESCALE);
    check_val("gated read", 32'h0000_0000, rd_data);
    wr(cbo_pkg::IDX_CTRL, 32'h0000_0001);
    rd(cbo_pkg::IDX_PRESCALE);
    check_val("prescale kept", 32'(last_bt0), rd_data);
    test_done();
  end
endmodule : cbo_bit_timing_test
